// File: core/adc_link_if.sv
/*
  pin-level carrier between converter end and host end.
  assumes both ends share core clock; resolves the shared pins from enables.
*/
`default_nettype none
interface adc_link_if;
  // chip select, driven by host only
  logic cs_n;
  // serial clock drivers and device weak pull-up
  logic host_sck_o;
  logic host_sck_oe;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_sck_pu;
  // serial data driver
  logic sdo_o;
  logic sdo_oe;
  // resolved pin levels
  logic sck;
  logic sdo;

  // undriven clock follows the pull-up; with pull-up off it reads low
  assign sck = host_sck_oe ? host_sck_o : (dev_sck_oe ? dev_sck_o : dev_sck_pu);
  // undriven data line floats, seen as high
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev (input cs_n, input sck, output dev_sck_o, output dev_sck_oe, output dev_sck_pu,
    output sdo_o, output sdo_oe);
  modport host (output cs_n, output host_sck_o, output host_sck_oe, input sck, input sdo);
endinterface
`default_nettype wire

// File: core/adc_link_pkg.sv
/*
  shared constants, types and helpers for the converter readout link.
  assumes a single 25 MHz core clock at both ends.
*/
`default_nettype none
package adc_link_pkg;
  // ---------------------------------------------------------------
  // word layout and clock ratios
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int WORD_W = 24;
  localparam int RESULT_W = 23;
  localparam int SCK_DIV = 8;
  localparam int SCK_HALF = SCK_DIV / 2;
  localparam int CONV_DIV = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int STATUS_TEST_NS = 23000;
  localparam int STATUS_TEST_CYC = (STATUS_TEST_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_TEST_EXT_X10 = 36;
  localparam int EXT_OSC_KHZ = 100;
  localparam int POR_NS = 500000;
  localparam int POR_CYC = POR_NS / CLK_NS;
  localparam int SETTLE_CYC = 8;
  localparam int HOST_HALF_CYC = 8;
  localparam int CNT_W = 16;
  localparam int BIT_W = 5;
  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DEV_CONVERT = 4'h1,
    DEV_SLEEP = 4'h2,
    DEV_WAIT = 4'h4,
    DEV_OUTPUT = 4'h8
  } dev_state_t;
  typedef enum logic [5:0] {
    HOST_IDLE = 6'h01,
    HOST_SELECT = 6'h02,
    HOST_POLL = 6'h04,
    HOST_CLK_LO = 6'h08,
    HOST_CLK_HI = 6'h10,
    HOST_RECV = 6'h20
  } host_state_t;

  // glitch filter: accept a change once stages two and three agree
  function automatic logic filt_next(input logic s2, input logic s3, input logic cur);
    filt_next = (s2 == s3) ? s3 : cur;
  endfunction

  // status test delay on an external oscillator, in core cycles, rounded up
  function automatic int ext_test_cyc(input int khz);
    ext_test_cyc = (STATUS_TEST_EXT_X10 * 100000 + khz * CLK_NS - 1) / (khz * CLK_NS);
  endfunction
endpackage
`default_nettype wire

// File: core/adc_readout_dev.sv
/*
  converter end of the serial readout link: mode pick, status flag,
  24-bit shift-out, abort, internal clock generation, clock pin pull-up.
  assumes the analog side pulses conv_done_in with a result after each start.
*/
//
// Summary of operation
// - chip select fall samples clock: low means external
// - data pin released while chip select high
// - data pin shows busy flag outside readout
// - finished conversion always enters sleep
// - sleep holds result until clock rises, select low
// - shift on falling edge; 24 bits incl flag
// - 24th external falling edge starts new conversion
// - external readout aborted by chip select rise
// - two-wire mode picked from clock at reset end
// - flag fall loads result into shift register
// - floating or high clock selects internal clock
// - internal mode: select low drives clock low
// - internal output starts after status test delay
// - select rise before delay keeps sleep, result
// - 24 internal cycles, then clock high, convert
// - internal readout aborted by chip select rise
// - select rise with clock low loses internal mode
// - pull-up off whenever clock pin low
// - status pulse in sleep re-enables pull-up
// - internal clock is conversion clock over eight
`default_nettype none
module adc_readout_dev #(
  parameter int POR_CYCLES = adc_link_pkg::POR_CYC,
  parameter int EXT_OSC_KHZ = adc_link_pkg::EXT_OSC_KHZ
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // link pins
  adc_link_if.dev link,
  // analog side
  input wire logic conv_done_in,
  input wire logic [adc_link_pkg::RESULT_W-1:0] result_in,
  input wire logic ext_osc_in,
  output logic conv_start_out,
  output logic mode_ext_out
);
  localparam int EXT_CYC = adc_link_pkg::ext_test_cyc(EXT_OSC_KHZ);
  localparam int W = adc_link_pkg::WORD_W;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic [2:0] cs_s;
  logic [2:0] sck_s;
  logic cs_f;
  logic sck_f;
  logic cs_p;
  logic sck_p;
  logic next_cs_f;
  logic next_sck_f;

  always_comb begin
    next_cs_f = adc_link_pkg::filt_next(cs_s[1], cs_s[2], cs_f);
    next_sck_f = adc_link_pkg::filt_next(sck_s[1], sck_s[2], sck_f);
  end

  // synchroniser and previous-sample registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_s <= 3'h7;
      sck_s <= 3'h7;
      cs_f <= 1'b1;
      sck_f <= 1'b1;
      cs_p <= 1'b1;
      sck_p <= 1'b1;
    end else begin
      cs_s <= {cs_s[1:0], link.cs_n};
      sck_s <= {sck_s[1:0], link.sck};
      cs_f <= next_cs_f;
      sck_f <= next_sck_f;
      cs_p <= cs_f;
      sck_p <= sck_f;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall = cs_p & ~cs_f;
  assign cs_rise = ~cs_p & cs_f;
  assign sck_rise = ~sck_p & sck_f;
  assign sck_fall = sck_p & ~sck_f;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  adc_link_pkg::dev_state_t state;
  adc_link_pkg::dev_state_t next_state;
  logic [W-1:0] shreg;
  logic [W-1:0] next_shreg;
  logic [adc_link_pkg::BIT_W-1:0] bit_cnt;
  logic [adc_link_pkg::BIT_W-1:0] next_bit_cnt;
  logic [adc_link_pkg::CNT_W-1:0] wait_cnt;
  logic [adc_link_pkg::CNT_W-1:0] next_wait_cnt;
  logic [adc_link_pkg::CNT_W-1:0] por_cnt;
  logic [adc_link_pkg::CNT_W-1:0] next_por_cnt;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic [1:0] half_cnt;
  logic [1:0] next_half_cnt;
  logic por_done;
  logic next_por_done;
  logic mode_ext;
  logic next_mode_ext;
  logic eff_ext;
  logic conv_tick;
  logic next_conv_start;
  logic sck_o;
  logic next_sck_o;
  logic sck_oe;
  logic next_sck_oe;
  logic pu;
  logic next_pu;
  logic sdo_o;
  logic next_sdo_o;
  logic sdo_oe;
  logic next_sdo_oe;
  logic [adc_link_pkg::CNT_W-1:0] test_last;

  assign test_last = ext_osc_in ? adc_link_pkg::CNT_W'(EXT_CYC - 1)
                                : adc_link_pkg::CNT_W'(adc_link_pkg::STATUS_TEST_CYC - 1);
  assign conv_tick = (div_cnt == 2'(adc_link_pkg::CONV_DIV - 1));
  // mode in force this cycle, including a select fall now
  assign eff_ext = cs_fall ? ~sck_f : mode_ext;

  // next-state logic for all sequencer state
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_wait_cnt = wait_cnt;
    next_por_cnt = por_cnt;
    next_por_done = por_done;
    next_mode_ext = mode_ext;
    next_conv_start = 1'b0;
    next_sck_o = sck_o;
    next_half_cnt = half_cnt;
    next_div_cnt = conv_tick ? 2'h0 : 2'(div_cnt + 2'h1);
    if (!por_done) begin
      next_por_cnt = adc_link_pkg::CNT_W'(por_cnt + 1'b1);
      // clock level at reset end picks mode
      if (por_cnt == adc_link_pkg::CNT_W'(POR_CYCLES - 1)) begin
        next_por_done = 1'b1;
        next_mode_ext = ~sck_f;
        next_conv_start = 1'b1;
      end
    end else begin
      if (cs_fall) begin
        next_mode_ext = ~sck_f;
        next_sck_o = 1'b0;
      end
      unique case (state)
        adc_link_pkg::DEV_CONVERT: begin
          if (conv_done_in) begin
            next_shreg = {1'b0, result_in};
            next_state = adc_link_pkg::DEV_SLEEP;
          end
        end
        adc_link_pkg::DEV_SLEEP: begin
          // leave sleep on a select-low clock rise, or on select low in internal mode
          if (!cs_f && eff_ext && sck_rise) begin
            next_state = adc_link_pkg::DEV_OUTPUT;
            next_bit_cnt = '0;
          end else if (!cs_f && !eff_ext) begin
            next_state = adc_link_pkg::DEV_WAIT;
            next_wait_cnt = '0;
          end
        end
        adc_link_pkg::DEV_WAIT: begin
          // early select rise returns to sleep
          if (cs_f) begin
            next_state = adc_link_pkg::DEV_SLEEP;
          end else if (wait_cnt == test_last) begin
            // first internal rise after delay, on a tick so the first high half is full
            if (conv_tick) begin
              next_state = adc_link_pkg::DEV_OUTPUT;
              next_sck_o = 1'b1;
              next_bit_cnt = 5'h01;
              next_half_cnt = 2'h0;
            end
          end else begin
            next_wait_cnt = adc_link_pkg::CNT_W'(wait_cnt + 1'b1);
          end
        end
        adc_link_pkg::DEV_OUTPUT: begin
          if (cs_rise) begin
            next_state = adc_link_pkg::DEV_CONVERT;
            next_conv_start = 1'b1;
          end else if (mode_ext) begin
            if (sck_fall) begin
              if (bit_cnt == 5'(W - 1)) begin
                next_state = adc_link_pkg::DEV_CONVERT;
                next_conv_start = 1'b1;
              end else begin
                next_shreg = {shreg[W-2:0], 1'b0};
                next_bit_cnt = 5'(bit_cnt + 5'h01);
              end
            end
          end else if (conv_tick) begin
            // half period of four conversion ticks
            next_half_cnt = 2'(half_cnt + 2'h1);
            if (half_cnt == 2'(adc_link_pkg::SCK_HALF - 1)) begin
              next_half_cnt = 2'h0;
              if (sck_o) begin
                if (bit_cnt == 5'(W)) begin
                  next_state = adc_link_pkg::DEV_CONVERT;
                  next_conv_start = 1'b1;
                end else begin
                  next_sck_o = 1'b0;
                  next_shreg = {shreg[W-2:0], 1'b0};
                end
              end else begin
                next_sck_o = 1'b1;
                next_bit_cnt = 5'(bit_cnt + 5'h01);
              end
            end
          end
        end
      endcase
    end
    // internal mode drives clock while selected
    next_sck_oe = por_done & ~cs_f & ~eff_ext;
    next_sdo_oe = ~cs_f;
    next_sdo_o = (next_state == adc_link_pkg::DEV_OUTPUT) ? next_shreg[W-1]
               : (next_state == adc_link_pkg::DEV_CONVERT);
    // pull-up follows pin, re-armed by status pulse
    next_pu = pu;
    if (state == adc_link_pkg::DEV_WAIT && cs_rise) begin
      next_pu = 1'b1;
    end else if (sck_fall) begin
      next_pu = 1'b0;
    end else if (sck_rise) begin
      next_pu = 1'b1;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= adc_link_pkg::DEV_CONVERT;
      shreg <= '0;
      bit_cnt <= '0;
      wait_cnt <= '0;
      por_cnt <= '0;
      por_done <= 1'b0;
      mode_ext <= 1'b0;
      div_cnt <= 2'h0;
      half_cnt <= 2'h0;
      conv_start_out <= 1'b0;
      sck_o <= 1'b1;
      sck_oe <= 1'b0;
      pu <= 1'b1;
      sdo_o <= 1'b1;
      sdo_oe <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      wait_cnt <= next_wait_cnt;
      por_cnt <= next_por_cnt;
      por_done <= next_por_done;
      mode_ext <= next_mode_ext;
      div_cnt <= next_div_cnt;
      half_cnt <= next_half_cnt;
      conv_start_out <= next_conv_start;
      sck_o <= next_sck_o;
      sck_oe <= next_sck_oe;
      pu <= next_pu;
      sdo_o <= next_sdo_o;
      sdo_oe <= next_sdo_oe;
    end
  end

  // pin drivers and status
  assign link.dev_sck_o = sck_o;
  assign link.dev_sck_oe = sck_oe;
  assign link.dev_sck_pu = pu;
  assign link.sdo_o = sdo_o;
  assign link.sdo_oe = sdo_oe;
  assign mode_ext_out = mode_ext;
endmodule
`default_nettype wire

// File: core/adc_readout_host.sv
/*
  host end of the serial readout link: selects clock mode, polls the
  busy flag, clocks or follows 24 bits, buffers words for the user.
  assumes the user pulses start_in and drains words with valid/ready.
*/
`default_nettype none
module adc_readout_host #(
  parameter int HALF_CYC = adc_link_pkg::HOST_HALF_CYC,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // link pins
  adc_link_if.host link,
  // user control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic ext_mode_in,
  output logic busy_out,
  // user data
  output logic [adc_link_pkg::WORD_W-1:0] word_out,
  output logic word_valid_out,
  input wire logic word_ready_in
);
  localparam int W = adc_link_pkg::WORD_W;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic [2:0] sck_s;
  logic [2:0] sdo_s;
  logic sck_f;
  logic sdo_f;
  logic sck_p;

  // three-stage sampling of device-driven pins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sck_s <= 3'h7;
      sdo_s <= 3'h7;
      sck_f <= 1'b1;
      sdo_f <= 1'b1;
      sck_p <= 1'b1;
    end else begin
      sck_s <= {sck_s[1:0], link.sck};
      sdo_s <= {sdo_s[1:0], link.sdo};
      sck_f <= adc_link_pkg::filt_next(sck_s[1], sck_s[2], sck_f);
      sdo_f <= adc_link_pkg::filt_next(sdo_s[1], sdo_s[2], sdo_f);
      sck_p <= sck_f;
    end
  end

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  adc_link_pkg::host_state_t state;
  adc_link_pkg::host_state_t next_state;
  logic [adc_link_pkg::CNT_W-1:0] cnt;
  logic [adc_link_pkg::CNT_W-1:0] next_cnt;
  logic [adc_link_pkg::BIT_W-1:0] bits;
  logic [adc_link_pkg::BIT_W-1:0] next_bits;
  logic [W-1:0] word;
  logic [W-1:0] next_word;
  logic ext_r;
  logic next_ext_r;
  logic cs_n;
  logic next_cs_n;
  logic sck_o;
  logic next_sck_o;
  logic sck_oe;
  logic next_sck_oe;
  logic push;
  logic next_push;
  logic next_busy;
  logic buf_ready;

  // next-state logic for the transfer
  always_comb begin
    next_state = state;
    next_cnt = adc_link_pkg::CNT_W'(cnt + 1'b1);
    next_bits = bits;
    next_word = word;
    next_ext_r = ext_r;
    next_cs_n = cs_n;
    next_sck_o = sck_o;
    next_push = 1'b0;
    unique case (state)
      adc_link_pkg::HOST_IDLE: begin
        // hold clock low ahead of select fall
        next_ext_r = ext_mode_in;
        next_sck_o = 1'b0;
        // ignore start while the buffer is full
        if (start_in && buf_ready) begin
          next_cs_n = 1'b0;
          next_cnt = '0;
          next_state = adc_link_pkg::HOST_SELECT;
        end
      end
      adc_link_pkg::HOST_SELECT: begin
        if (cnt == adc_link_pkg::CNT_W'(adc_link_pkg::SETTLE_CYC - 1)) begin
          next_state = adc_link_pkg::HOST_POLL;
        end
      end
      adc_link_pkg::HOST_POLL: begin
        if (!sdo_f) begin
          next_bits = '0;
          next_cnt = '0;
          next_state = ext_r ? adc_link_pkg::HOST_CLK_LO : adc_link_pkg::HOST_RECV;
        end
      end
      adc_link_pkg::HOST_CLK_LO: begin
        if (cnt == adc_link_pkg::CNT_W'(HALF_CYC - 1)) begin
          next_sck_o = 1'b1;
          next_cnt = '0;
          next_state = adc_link_pkg::HOST_CLK_HI;
        end
      end
      adc_link_pkg::HOST_CLK_HI: begin
        // latch late in the high half, then fall
        if (cnt == adc_link_pkg::CNT_W'(HALF_CYC - 1)) begin
          next_word = {word[W-2:0], sdo_f};
          next_bits = 5'(bits + 5'h01);
          next_sck_o = 1'b0;
          next_cnt = '0;
          next_state = adc_link_pkg::HOST_CLK_LO;
          if (bits == 5'(W - 1)) begin
            next_push = 1'b1;
            next_state = adc_link_pkg::HOST_IDLE;
          end
        end
      end
      adc_link_pkg::HOST_RECV: begin
        if (~sck_p & sck_f) begin
          next_word = {word[W-2:0], sdo_f};
          next_bits = 5'(bits + 5'h01);
          if (bits == 5'(W - 1)) begin
            next_push = 1'b1;
            next_state = adc_link_pkg::HOST_IDLE;
          end
        end
      end
    endcase
    if (next_state == adc_link_pkg::HOST_IDLE) begin
      next_cs_n = 1'b1;
    end
    if (abort_in && state != adc_link_pkg::HOST_IDLE) begin
      next_cs_n = 1'b1;
      next_push = 1'b0;
      next_state = adc_link_pkg::HOST_IDLE;
    end
    // release the clock for internal mode
    next_sck_oe = (next_state == adc_link_pkg::HOST_IDLE) ? ext_mode_in : next_ext_r;
    next_busy = (next_state != adc_link_pkg::HOST_IDLE);
  end

  // transfer registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= adc_link_pkg::HOST_IDLE;
      cnt <= '0;
      bits <= '0;
      word <= '0;
      ext_r <= 1'b0;
      cs_n <= 1'b1;
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      push <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bits <= next_bits;
      word <= next_word;
      ext_r <= next_ext_r;
      cs_n <= next_cs_n;
      sck_o <= next_sck_o;
      sck_oe <= next_sck_oe;
      push <= next_push;
      busy_out <= next_busy;
    end
  end

  assign link.cs_n = cs_n;
  assign link.host_sck_o = sck_o;
  assign link.host_sck_oe = sck_oe;

  // word buffer between link and user
  word_buffer #(
    .WIDTH(W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(push),
    .in_ready_out(buf_ready),
    .in_data_in(word),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(word_out)
  );
endmodule
`default_nettype wire

// File: core/word_buffer.sv
/*
  small shift-style buffer with valid/ready on both sides.
  assumes one clock; head entry is a flop, so out side is registered.
*/
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] data [DEPTH];
  logic [WIDTH-1:0] next_data [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;

  assign in_ready_out = ~vld[DEPTH-1];
  assign out_valid_out = vld[0];
  assign out_data_out = data[0];

  // pop shifts toward head, push fills first free slot
  always_comb begin
    logic placed;
    placed = 1'b0;
    next_data = data;
    next_vld = vld;
    if (vld[0] && out_ready_in) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_data[i] = data[i + 1];
        next_vld[i] = vld[i + 1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    if (in_valid_in && in_ready_out) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_vld[i]) begin
          next_data[i] = in_data_in;
          next_vld[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  // storage registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        data[i] <= '0;
      end
    end else begin
      vld <= next_vld;
      data <= next_data;
    end
  end
endmodule
`default_nettype wire

// File: dv/adc_link_assertions.sv
/* pin checks for the readout link.
   assumes one core clock; sees the interface signals as plain inputs. */
`default_nettype none
module adc_link_assertions (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // link pins
  input wire logic cs_n,
  input wire logic host_sck_oe,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_sck_pu,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sck
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ------------------------------
  // select and clock rules
  // ------------------------------
  sequence s_fall_lo;
    $fell(cs_n) && host_sck_oe && !sck;
  endsequence
  sequence s_fall_hi;
    $fell(cs_n) && !host_sck_oe && sck;
  endsequence
  property p_ext_pick; s_fall_lo |-> (!dev_sck_oe)[*8]; endproperty
  property p_oe_off; (cs_n)[*8] |-> !sdo_oe; endproperty
  property p_oe_on; (!cs_n)[*8] |-> sdo_oe; endproperty
  property p_int_drive; s_fall_hi |-> ##[1:10] (dev_sck_oe && !dev_sck_o); endproperty
  property p_pu_off; (!sck && !cs_n)[*6] |-> !dev_sck_pu; endproperty
  property p_int_high; $rose(dev_sck_o) && dev_sck_oe |-> (dev_sck_o || cs_n)[*8]; endproperty
  property p_int_low; $fell(dev_sck_o) && dev_sck_oe |-> (!dev_sck_o || cs_n)[*8]; endproperty
  property p_shift; host_sck_oe && !cs_n && sck && $past(sck) |-> $stable(sdo_o); endproperty
  a_ext_pick: assert property (p_ext_pick) else $error("device drove clock in external mode");
  a_oe_off: assert property (p_oe_off) else $error("data driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("data not driven while selected");
  a_int_drive: assert property (p_int_drive) else $error("clock not pulled low on select");
  a_pu_off: assert property (p_pu_off) else $error("pull-up on with clock low");
  a_int_high: assert property (p_int_high) else $error("internal clock high half short");
  a_int_low: assert property (p_int_low) else $error("internal clock low half short");
  a_shift: assert property (p_shift) else $error("data changed while clock high");
endmodule
`default_nettype wire

// File: dv/testbench.sv
/* top bench: both link ends joined, analog side modelled here.
   assumes the core files are compiled first. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic conv_done = 1'b0, start = 1'b0, abort = 1'b0, ext_mode = 1'b0, ext_osc = 1'b0;
  logic word_ready = 1'b1, stall = 1'b0, conv_start, mode_ext, busy, word_valid;
  logic [22:0] result = 23'h0;
  logic [23:0] word;
  logic [23:0] exp_q[$];
  int err_count = 0, n_checks = 0, seed = 60, conv_cnt = 0, wait_cnt = 0, c;
  adc_link_if link ();
  adc_readout_dev #(.POR_CYCLES(20), .EXT_OSC_KHZ(100)) adc_readout_dev_i (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .link(link.dev), .conv_done_in(conv_done), .result_in(result),
    .ext_osc_in(ext_osc), .conv_start_out(conv_start), .mode_ext_out(mode_ext));
  adc_readout_host #(.HALF_CYC(8), .BUF_DEPTH(2)) adc_readout_host_i (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .link(link.host), .start_in(start), .abort_in(abort), .ext_mode_in(ext_mode),
    .busy_out(busy), .word_out(word), .word_valid_out(word_valid), .word_ready_in(word_ready));
  adc_link_assertions adc_link_assertions_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .cs_n(link.cs_n), .host_sck_oe(link.host_sck_oe), .dev_sck_o(link.dev_sck_o),
    .dev_sck_oe(link.dev_sck_oe), .dev_sck_pu(link.dev_sck_pu), .sdo_o(link.sdo_o),
    .sdo_oe(link.sdo_oe), .sck(link.sck));
  // ------------------------------
  // clock, analog side, word sink
  // ------------------------------
  initial forever #20 core_clk_in = ~core_clk_in;
  // finish each conversion after a varying delay, fresh result each time
  always @(negedge core_clk_in) begin
    conv_done <= 1'b0;
    if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    if (wait_cnt == 1) begin
      conv_done <= 1'b1;
      result <= 23'h1ABCDE ^ 23'(conv_cnt * 32'h9E3779B1);
    end
    if (conv_start === 1'b1) begin
      conv_cnt <= conv_cnt + 1;
      wait_cnt <= 60 + (conv_cnt % 64);
    end
  end
  // each popped word must match the oldest finished readout
  always @(posedge core_clk_in) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) chk("word", exp_q.pop_front(), word);
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one readout; ab above zero aborts after that many cycles
  task automatic xfer(input logic ext, input int ab, input logic em);
    int n;
    ext_mode <= ext;
    repeat (150) @(negedge core_clk_in);
    start <= 1'b1;
    @(negedge core_clk_in);
    start <= 1'b0;
    if (ab > 0) begin
      repeat (ab) @(negedge core_clk_in);
      abort <= 1'b1;
      @(negedge core_clk_in);
      abort <= 1'b0;
    end
    n = 0;
    while (busy !== 1'b0) begin
      word_ready <= stall ? 1'b0 : 1'($random(seed));
      @(negedge core_clk_in);
      n++;
      if (n > 3000) begin
        err_count++;
        report_and_stop();
      end
    end
    if (ab == 0) exp_q.push_back({1'b0, result});
    // let a select rise reach the device before counting conversions
    repeat (12) @(negedge core_clk_in);
    chk("mode", 24'(em), 24'(mode_ext));
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (10) @(negedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (40) @(negedge core_clk_in);
    chk("mode", 24'h0, 24'(mode_ext));
    for (int i = 0; i < 3; i++) begin
      ext_osc <= 1'($random(seed));
      xfer(1'b0, 0, 1'b0);
    end
    c = conv_cnt;
    xfer(1'b0, 50, 1'b0);
    chk("conv", 24'(c), 24'(conv_cnt));
    xfer(1'b0, 0, 1'b0);
    // abort an internal readout in a high half of the clock
    ext_osc <= 1'b0;
    c = conv_cnt;
    xfer(1'b0, 690, 1'b0);
    chk("conv", 24'(c + 1), 24'(conv_cnt));
    for (int i = 0; i < 4; i++) xfer(1'b1, 0, 1'b1);
    c = conv_cnt;
    xfer(1'b1, 30 + ($random(seed) & 255), 1'b1);
    chk("conv", 24'(c + 1), 24'(conv_cnt));
    word_ready <= 1'b1;
    stall <= 1'b1;
    xfer(1'b1, 0, 1'b1);
    xfer(1'b1, 0, 1'b1);
    start <= 1'b1;
    @(negedge core_clk_in);
    start <= 1'b0;
    @(negedge core_clk_in);
    chk("busy", 24'h0, 24'(busy));
    stall <= 1'b0;
    word_ready <= 1'b1;
    repeat (10) @(negedge core_clk_in);
    chk("queue", 24'h0, 24'(exp_q.size()));
    xfer(1'b0, 300, 1'b1);
    // second reset with the host holding the clock low
    ext_mode <= 1'b1;
    repeat (5) @(negedge core_clk_in);
    arst_n_in <= 1'b0;
    repeat (10) @(negedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (40) @(negedge core_clk_in);
    chk("mode", 24'h1, 24'(mode_ext));
    report_and_stop();
  end
endmodule
`default_nettype wire
